/* File: core/link_supervision_timers.sv */
`timescale 1ns/1ps
module link_supervision_timers #(
   parameter int TICK_CYCLES = link_sup_pkg::TICK_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        linkUp,
   input  wire logic        connEstablished,
   input  wire logic        connFail,
   input  wire logic        trafficSeen,
   input  wire logic        probeReplyRx,
   input  wire logic        frameSent,
   input  wire logic        ackRx,
   input  wire logic        wdogCycleLoad,
   input  wire logic [15:0] wdogCycleValue,
   input  wire logic        wdogReplyRx,
   output logic             sendProbe,
   output logic             closeConn,
   output logic             resendFrame,
   output logic             sendWdog,
   output logic             reconnectReq,
   output logic             keyRenew
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic        probeEn;
      logic        override;
      logic [15:0] idleGlobal;
      logic [15:0] idlePartner;
      logic [15:0] probeReply;
      logic [15:0] reconBase;
      logic [15:0] ackWait;
      logic [15:0] wdReply;
      logic [15:0] keyIval;
      logic [15:0] wdCycle;
      logic [15:0] idleCnt;
      logic [15:0] probeCnt;
      logic [15:0] reconCnt;
      logic [15:0] ackCnt;
      logic [15:0] wdCnt;
      logic [15:0] wdRepCnt;
      logic [15:0] keyCnt;
      logic [15:0] curWait;
      logic        probePend;
      logic        reconActive;
      logic        ackPend;
      logic        wdPend;
      logic [1:0]  failCnt;
      logic [1:0]  ackTries;
      logic        sendProbe;
      logic        closeConn;
      logic        resendFrame;
      logic        sendWdog;
      logic        reconnectReq;
      logic        keyRenew;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } st_t;

   st_t  s;
   st_t  next_s;
   logic tick;

   sec_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tick    (tick)
   );

   function automatic logic [15:0] inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h0001;
   endfunction

   function automatic logic due(input logic [15:0] cnt,
                                input logic [15:0] per);
      return inc(cnt) >= per;
   endfunction

   function automatic logic [15:0] clampv(input logic [31:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
      if (v < {16'h0000, lo}) return lo;
      if (v > {16'h0000, hi}) return hi;
      return v[15:0];
   endfunction

   logic [15:0] effIdle;
   logic        drop;
   logic [16:0] dbl;

   always_comb begin
      next_s = s;
      drop = 1'b0;
      dbl = '0;
      next_s.sendProbe = 1'b0;
      next_s.closeConn = 1'b0;
      next_s.resendFrame = 1'b0;
      next_s.sendWdog = 1'b0;
      next_s.reconnectReq = 1'b0;
      next_s.keyRenew = 1'b0;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      effIdle = s.override ? s.idlePartner : s.idleGlobal;

      // -------------------------------------------------------------
      // APB slave, one wait state
      // -------------------------------------------------------------
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = '0;
         case (paddr)
            link_sup_pkg::OFS_CTRL: begin
               if (pwrite) begin
                  next_s.probeEn = pwdata[link_sup_pkg::CTRL_PROBE_EN];
                  next_s.override = pwdata[link_sup_pkg::CTRL_OVERRIDE];
               end
               next_s.prdata[link_sup_pkg::CTRL_PROBE_EN] = s.probeEn;
               next_s.prdata[link_sup_pkg::CTRL_OVERRIDE] = s.override;
            end
            link_sup_pkg::OFS_IDLE_GLOBAL: begin
               if (pwrite) next_s.idleGlobal =
                  clampv(pwdata, link_sup_pkg::PERIOD_MIN, 16'hffff);
               next_s.prdata[15:0] = s.idleGlobal;
            end
            link_sup_pkg::OFS_IDLE_PARTNER: begin
               if (pwrite) next_s.idlePartner =
                  clampv(pwdata, link_sup_pkg::PERIOD_MIN, 16'hffff);
               next_s.prdata[15:0] = s.idlePartner;
            end
            link_sup_pkg::OFS_PROBE_REPLY: begin
               if (pwrite) next_s.probeReply =
                  clampv(pwdata, link_sup_pkg::PERIOD_MIN, 16'hffff);
               next_s.prdata[15:0] = s.probeReply;
            end
            link_sup_pkg::OFS_RECON_BASE: begin
               if (pwrite) next_s.reconBase = clampv(pwdata,
                  link_sup_pkg::RECON_MIN, link_sup_pkg::RECON_MAX);
               next_s.prdata[15:0] = s.reconBase;
            end
            link_sup_pkg::OFS_ACK_WAIT: begin
               if (pwrite) next_s.ackWait =
                  clampv(pwdata, link_sup_pkg::PERIOD_MIN, 16'hffff);
               next_s.prdata[15:0] = s.ackWait;
            end
            link_sup_pkg::OFS_WDOG_REPLY: begin
               if (pwrite) next_s.wdReply = clampv(pwdata, 16'h0000, 16'hffff);
               next_s.prdata[15:0] = s.wdReply;
            end
            link_sup_pkg::OFS_KEY_IVAL: begin
               if (pwrite) next_s.keyIval = clampv(pwdata, 16'h0000, 16'hffff);
               next_s.prdata[15:0] = s.keyIval;
            end
            link_sup_pkg::OFS_STATUS: begin
               next_s.prdata[link_sup_pkg::ST_LINK] = linkUp;
               next_s.prdata[link_sup_pkg::ST_PROBE] = s.probePend;
               next_s.prdata[link_sup_pkg::ST_ACK] = s.ackPend;
               next_s.prdata[link_sup_pkg::ST_WDOG] = s.wdPend;
               next_s.prdata[link_sup_pkg::ST_TRIES +: 2] = s.ackTries;
               next_s.prdata[link_sup_pkg::ST_RECON] = s.reconActive;
            end
            link_sup_pkg::OFS_WAIT_NOW: next_s.prdata[15:0] = s.curWait;
            link_sup_pkg::OFS_WDOG_CYCLE: next_s.prdata[15:0] = s.wdCycle;
            default: next_s.pslverr = 1'b1;
         endcase
      end

      // -------------------------------------------------------------
      // Idle probe and probe reply; only while linkUp and probeEn
      // -------------------------------------------------------------
      if (!linkUp || !s.probeEn) begin
         next_s.idleCnt = '0;
         next_s.probePend = 1'b0;
      end else if (s.probePend) begin
         if (probeReplyRx) begin
            next_s.probePend = 1'b0;
         end else if (tick) begin
            next_s.probeCnt = inc(s.probeCnt);
            if (due(s.probeCnt, s.probeReply)) begin
               drop = 1'b1;
               next_s.probePend = 1'b0;
            end
         end
      end else if (trafficSeen) begin
         next_s.idleCnt = '0;
      end else if (tick) begin
         next_s.idleCnt = inc(s.idleCnt);
         if (due(s.idleCnt, effIdle)) begin
            next_s.sendProbe = 1'b1;
            next_s.probePend = 1'b1;
            next_s.probeCnt = '0;
            next_s.idleCnt = '0;
         end
      end

      // -------------------------------------------------------------
      // Acknowledge wait and frame repeats
      // -------------------------------------------------------------
      if (!linkUp) begin
         next_s.ackPend = 1'b0;
      end else if (frameSent) begin
         next_s.ackPend = 1'b1;
         next_s.ackCnt = '0;
         next_s.ackTries = '0;
      end else if (s.ackPend) begin
         if (ackRx) begin
            next_s.ackPend = 1'b0;
         end else if (tick) begin
            next_s.ackCnt = inc(s.ackCnt);
            if (due(s.ackCnt, s.ackWait)) begin
               next_s.ackCnt = '0;
               if (s.ackTries == link_sup_pkg::ACK_REPEATS) begin
                  drop = 1'b1;
                  next_s.ackPend = 1'b0;
               end else begin
                  next_s.resendFrame = 1'b1;
                  next_s.ackTries = s.ackTries + 2'h1;
               end
            end
         end
      end

      // -------------------------------------------------------------
      // Watchdog cycle and watchdog reply
      // -------------------------------------------------------------
      if (wdogCycleLoad) next_s.wdCycle = wdogCycleValue;
      if (!linkUp) begin
         next_s.wdCnt = '0;
         next_s.wdPend = 1'b0;
      end else if (s.wdPend) begin
         if (wdogReplyRx || s.wdReply == 16'h0000) begin
            next_s.wdPend = 1'b0;
         end else if (tick) begin
            next_s.wdRepCnt = inc(s.wdRepCnt);
            if (due(s.wdRepCnt, s.wdReply)) begin
               drop = 1'b1;
               next_s.wdPend = 1'b0;
            end
         end
      end else if (ackRx || s.wdCycle == 16'h0000) begin
         next_s.wdCnt = '0;
      end else if (tick) begin
         next_s.wdCnt = inc(s.wdCnt);
         if (due(s.wdCnt, s.wdCycle)) begin
            next_s.sendWdog = 1'b1;
            next_s.wdCnt = '0;
            next_s.wdRepCnt = '0;
            next_s.wdPend = s.wdReply != 16'h0000;
         end
      end

      // -------------------------------------------------------------
      // Key renewal
      // -------------------------------------------------------------
      if (!linkUp || s.keyIval == 16'h0000) begin
         next_s.keyCnt = '0;
      end else if (tick) begin
         next_s.keyCnt = inc(s.keyCnt);
         if (due(s.keyCnt, s.keyIval)) begin
            next_s.keyRenew = 1'b1;
            next_s.keyCnt = '0;
         end
      end

      // -------------------------------------------------------------
      // Reconnection back-off
      // -------------------------------------------------------------
      next_s.closeConn = drop;
      if (connEstablished) begin
         next_s.curWait = s.reconBase;
         next_s.failCnt = '0;
         next_s.reconActive = 1'b0;
      end else if (drop || connFail) begin
         next_s.reconActive = 1'b1;
         next_s.reconCnt = '0;
         if (connFail) begin
            next_s.failCnt = s.failCnt + 2'h1;
            if (s.failCnt + 2'h1 == link_sup_pkg::FAILS_PER_STEP) begin
               next_s.failCnt = '0;
               dbl = {s.curWait, 1'b0};
               next_s.curWait = (dbl > {1'b0, link_sup_pkg::WAIT_CEIL}) ?
                  link_sup_pkg::WAIT_CEIL : dbl[15:0];
            end
         end
      end else if (s.reconActive && tick) begin
         next_s.reconCnt = inc(s.reconCnt);
         if (due(s.reconCnt, s.curWait)) begin
            next_s.reconnectReq = 1'b1;
            next_s.reconActive = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s <= '0;
         s.idleGlobal <= link_sup_pkg::IDLE_DEF;
         s.idlePartner <= link_sup_pkg::IDLE_DEF;
         s.probeReply <= link_sup_pkg::PROBE_DEF;
         s.reconBase <= link_sup_pkg::RECON_DEF;
         s.curWait <= link_sup_pkg::RECON_DEF;
         s.ackWait <= link_sup_pkg::ACK_DEF;
         s.wdReply <= link_sup_pkg::WDOG_REPLY_DEF;
         s.keyIval <= link_sup_pkg::KEY_DEF;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign sendProbe = s.sendProbe;
   assign closeConn = s.closeConn;
   assign resendFrame = s.resendFrame;
   assign sendWdog = s.sendWdog;
   assign reconnectReq = s.reconnectReq;
   assign keyRenew = s.keyRenew;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   AST_PROBE_ARMS: assert property (sendProbe |-> s.probePend &&
      s.idleCnt == 16'h0000) else $error("probe without pending reply");
   AST_PROBE_TIMEOUT: assert property (s.probePend && tick && linkUp &&
      s.probeEn && !probeReplyRx && inc(s.probeCnt) >= s.probeReply
      |=> closeConn) else $error("probe timeout did not close");
   AST_PROBE_GATED: assert property (!s.probeEn |=> !sendProbe)
      else $error("probe while supervision off");
   AST_WAIT_CEIL: assert property (s.curWait <= link_sup_pkg::WAIT_CEIL)
      else $error("back-off wait above ceiling");
   AST_BASE_RANGE: assert property (s.reconBase >= link_sup_pkg::RECON_MIN
      && s.reconBase <= link_sup_pkg::RECON_MAX) else $error("base range");
   AST_WAIT_FIRST: assert property (reconnectReq |-> $past(s.reconActive)
      && !s.reconActive) else $error("reconnect without wait");
   AST_RESEND_COUNT: assert property (resendFrame |-> s.ackTries != 2'h0
      ##1 !resendFrame) else $error("resend count wrong");
   AST_WDOG_OFF: assert property (sendWdog && s.wdReply == 16'h0000
      |-> !s.wdPend) else $error("watchdog reply armed while disabled");
   AST_KEY_OFF: assert property (s.keyIval == 16'h0000 [*2] |-> !keyRenew)
      else $error("key renewal while disabled");
   AST_WDOG_RESTART: assert property (linkUp && ackRx && !s.wdPend
      |=> s.wdCnt == 16'h0000) else $error("ack did not restart cycle");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) $past(reset)
      |-> s.idleCnt == 16'h0000 && !s.reconActive) else $error("reset");

   COV_PROBE: cover property (sendProbe ##[1:1000] probeReplyRx);
   COV_RESEND: cover property (resendFrame);
   COV_RECON: cover property (closeConn ##[1:1000] reconnectReq);
endmodule // link_supervision_timers

/* File: core/sec_tick_gen.sv */
`timescale 1ns/1ps
module sec_tick_gen #(
   parameter int CYCLES = link_sup_pkg::TICK_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   output logic      tick
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } tk_t;

   tk_t s;
   tk_t next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == LAST) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule // sec_tick_gen

/* File: shared/link_sup_pkg.sv */
package link_sup_pkg;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1_000_000_000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SEC_W = 16;
   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_IDLE_GLOBAL = 8'h04;
   localparam logic [7:0] OFS_IDLE_PARTNER = 8'h08;
   localparam logic [7:0] OFS_PROBE_REPLY = 8'h0c;
   localparam logic [7:0] OFS_RECON_BASE = 8'h10;
   localparam logic [7:0] OFS_ACK_WAIT = 8'h14;
   localparam logic [7:0] OFS_WDOG_REPLY = 8'h18;
   localparam logic [7:0] OFS_KEY_IVAL = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_WAIT_NOW = 8'h24;
   localparam logic [7:0] OFS_WDOG_CYCLE = 8'h28;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CTRL_PROBE_EN = 0;
   localparam int CTRL_OVERRIDE = 1;
   localparam int ST_LINK = 0;
   localparam int ST_PROBE = 1;
   localparam int ST_ACK = 2;
   localparam int ST_WDOG = 3;
   localparam int ST_TRIES = 4;
   localparam int ST_RECON = 6;
   // -------------------------------------------------------------
   // Reset values and limits, in seconds; FAILS_PER_STEP and ACK_REPEATS are counts
   // -------------------------------------------------------------
   localparam logic [15:0] IDLE_DEF = 16'h00b4;
   localparam logic [15:0] PROBE_DEF = 16'h00b4;
   localparam logic [15:0] RECON_DEF = 16'h000a;
   localparam logic [15:0] RECON_MIN = 16'h000a;
   localparam logic [15:0] RECON_MAX = 16'h012c;
   localparam logic [15:0] WAIT_CEIL = 16'h0384;
   localparam logic [15:0] ACK_DEF = 16'h003c;
   localparam logic [15:0] WDOG_REPLY_DEF = 16'h001e;
   localparam logic [15:0] KEY_DEF = 16'h0008;
   localparam logic [15:0] PERIOD_MIN = 16'h0001;
   localparam logic [1:0] FAILS_PER_STEP = 2'h3;
   localparam logic [1:0] ACK_REPEATS = 2'h3;
endpackage

/* File: testbench/link_supervision_timers_bench.sv */
`timescale 1ns/1ps
module link_supervision_timers_bench;
   localparam int T = 10;
   localparam int PROBE = 0;
   localparam int CLOSE = 1;
   localparam int RESEND = 2;
   localparam int WDOG = 3;
   localparam int RECON = 4;
   localparam int KEY = 5;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        linkUp = 1'b0;
   logic        answerOn = 1'b1;
   logic [3:0]  ev = 4'h0;
   logic        probeReplyRx;
   logic        ackRx;
   logic        wdogReplyRx;
   logic        wdogCycleLoad;
   logic [15:0] wdogCycleValue;
   logic [5:0]  outs;
   int          cnt [6];
   int          errorCnt = 0;
   int          numChecks = 0;
   logic [31:0] rdData;
   logic        rdErr;
   logic [15:0] defVal [10] = '{16'h0000, 16'h00b4, 16'h00b4, 16'h00b4,
      16'h000a, 16'h003c, 16'h001e, 16'h0008, 16'h000a, 16'h0000};

   always #5 clk_sys = ~clk_sys;

   link_supervision_timers #(.TICK_CYCLES(T)) DUT (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .linkUp(linkUp),
      .connEstablished(ev[0]), .connFail(ev[1]), .trafficSeen(ev[3]),
      .probeReplyRx(probeReplyRx), .frameSent(ev[2]), .ackRx(ackRx),
      .wdogCycleLoad(wdogCycleLoad), .wdogCycleValue(wdogCycleValue),
      .wdogReplyRx(wdogReplyRx), .sendProbe(outs[PROBE]),
      .closeConn(outs[CLOSE]), .resendFrame(outs[RESEND]),
      .sendWdog(outs[WDOG]), .reconnectReq(outs[RECON]),
      .keyRenew(outs[KEY]));

   server_link_model SRV (
      .clk_sys(clk_sys), .reset(reset), .answerOn(answerOn),
      .sendProbe(outs[PROBE]), .sendWdog(outs[WDOG]), .frameSent(ev[2]),
      .connEstablished(ev[0]), .probeReplyRx(probeReplyRx),
      .wdogReplyRx(wdogReplyRx), .ackRx(ackRx),
      .wdogCycleLoad(wdogCycleLoad), .wdogCycleValue(wdogCycleValue));

   // ------------------------------------------------------------
   // Pulse counting, off the launching edge
   // ------------------------------------------------------------
   always @(negedge clk_sys) begin
      foreach (cnt[i]) cnt[i] += int'(outs[i] === 1'b1);
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cntChk(string nm, int idx, int e);
      chk(nm, 32'(e), 32'(cnt[idx]));
   endtask

   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) errorCnt++;
      @(posedge clk_sys);
   endtask

   task automatic wr(logic [7:0] a, logic [15:0] v);
      apb(1'b1, a, {16'h0000, v});
   endtask

   task automatic rdChk(string nm, logic [7:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdData);
   endtask

   task automatic pulse(int i);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic waitc(int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic clr();
      cnt = '{default: 0};
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int w;
      logic [7:0] a;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
         a = (i < 8) ? 8'(4 * i) : 8'(4 * i + 4);
         rdChk("reset value", a, {16'h0, defVal[i]});
      end
      apb(1'b0, 8'h2c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rdErr});
      chk("unmapped data", 32'h0, rdData);
      wr(link_sup_pkg::OFS_RECON_BASE, 16'h0005);
      rdChk("base low", link_sup_pkg::OFS_RECON_BASE, 32'h0a);
      wr(link_sup_pkg::OFS_RECON_BASE, 16'h0190);
      rdChk("base high", link_sup_pkg::OFS_RECON_BASE, 32'h12c);
      wr(link_sup_pkg::OFS_IDLE_GLOBAL, 16'h0000);
      rdChk("idle min", link_sup_pkg::OFS_IDLE_GLOBAL, 32'h1);
      // Key renewal, then disabled
      wr(link_sup_pkg::OFS_KEY_IVAL, 16'h0002);
      clr();
      linkUp <= 1'b1;
      waitc(4 * T + 5);
      cntChk("key renew", KEY, 2);
      wr(link_sup_pkg::OFS_KEY_IVAL, 16'h0000);
      clr();
      waitc(5 * T);
      cntChk("key off", KEY, 0);
      // Probing gated, then partner override
      wr(link_sup_pkg::OFS_PROBE_REPLY, 16'h0002);
      wr(link_sup_pkg::OFS_IDLE_GLOBAL, 16'h0002);
      wr(link_sup_pkg::OFS_IDLE_PARTNER, 16'h0004);
      clr();
      waitc(4 * T);
      cntChk("probe off", PROBE, 0);
      wr(link_sup_pkg::OFS_CTRL, 16'h0003);
      clr();
      waitc(3 * T - 2);
      cntChk("partner early", PROBE, 0);
      waitc(T + 5);
      cntChk("partner probe", PROBE, 1);
      waitc(3 * T);
      cntChk("answered", CLOSE, 0);
      // Unanswered probe closes, then a reconnect wait of RECON_DEF
      wr(link_sup_pkg::OFS_CTRL, 16'h0000);
      answerOn <= 1'b0;
      wr(link_sup_pkg::OFS_CTRL, 16'h0001);
      clr();
      repeat (12) pulse(3);
      cntChk("traffic holds", PROBE, 0);
      waitc(2 * T + 3);
      cntChk("global probe", PROBE, 1);
      waitc(2 * T + 2);
      cntChk("probe timeout", CLOSE, 1);
      wr(link_sup_pkg::OFS_CTRL, 16'h0000);
      waitc(5 * T);
      cntChk("wait early", RECON, 0);
      waitc(6 * T);
      cntChk("wait done", RECON, 1);
      // Back-off doubling every third failure, capped
      for (int b = 0; b < 2; b++) begin
         w = b ? 300 : 10;
         wr(link_sup_pkg::OFS_RECON_BASE, 16'(w));
         pulse(0);
         rdChk("wait base", link_sup_pkg::OFS_WAIT_NOW, 32'(w));
         for (int f = 1; f <= 6; f++) begin
            pulse(1);
            if (f % 3 == 0) w = (2 * w > 900) ? 900 : 2 * w;
            rdChk("wait now", link_sup_pkg::OFS_WAIT_NOW, 32'(w));
         end
      end
      rdChk("wd cycle", link_sup_pkg::OFS_WDOG_CYCLE, 32'h2);
      // Acknowledge wait and repeats
      wr(link_sup_pkg::OFS_WDOG_REPLY, 16'h0000);
      wr(link_sup_pkg::OFS_ACK_WAIT, 16'h0002);
      clr();
      pulse(2);
      waitc(3);
      for (int k = 1; k <= 3; k++) begin
         waitc(2 * T);
         cntChk("resend", RESEND, k);
         if (k == 1) rdChk("status", link_sup_pkg::OFS_STATUS, 32'h55);
      end
      waitc(2 * T);
      cntChk("ack drop", CLOSE, 1);
      cntChk("resend max", RESEND, 3);
      answerOn <= 1'b1;
      clr();
      pulse(2);
      waitc(6 * T);
      cntChk("acked", RESEND, 0);
      // Watchdog frame and its reply
      wr(link_sup_pkg::OFS_WDOG_REPLY, 16'h0001);
      clr();
      waitc(5 * T);
      chk("wd sent", 32'h1, 32'(cnt[WDOG] > 0));
      cntChk("wd answered", CLOSE, 0);
      answerOn <= 1'b0;
      clr();
      waitc(5 * T);
      chk("wd drop", 32'h1, 32'(cnt[CLOSE] > 0));
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errorCnt++;
      tally_and_finish();
   end
endmodule // link_supervision_timers_bench

/* File: testbench/server_link_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Remote server: answers probes, watchdogs and frames when allowed
// ---------------------------------------------------------------
module server_link_model #(
   parameter logic [15:0] CYCLE_SEC = 16'h0002,
   parameter int          DELAY     = 3
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        answerOn,
   input  wire logic        sendProbe,
   input  wire logic        sendWdog,
   input  wire logic        frameSent,
   input  wire logic        connEstablished,
   output logic             probeReplyRx,
   output logic             wdogReplyRx,
   output logic             ackRx,
   output logic             wdogCycleLoad,
   output logic      [15:0] wdogCycleValue
);
   int         dly [3];
   logic [2:0] ans = 3'h0;
   logic [2:0] trig;
   logic       load = 1'b0;

   assign trig = {frameSent, sendWdog, sendProbe};
   assign {ackRx, wdogReplyRx, probeReplyRx} = ans;
   assign wdogCycleLoad = load;
   // Value line shows junk outside the load pulse, as a real bus would
   assign wdogCycleValue = load ? CYCLE_SEC : ~CYCLE_SEC;

   always @(posedge clk_sys) begin
      for (int i = 0; i < 3; i++) begin
         // One assignment per edge: pulse only on the last count
         ans[i] <= !reset && !(trig[i] === 1'b1 && answerOn) && dly[i] == 1;
         if (reset) begin
            dly[i] <= 0;
         end else if (trig[i] === 1'b1 && answerOn) begin
            dly[i] <= DELAY;
         end else if (dly[i] > 0) begin
            dly[i] <= dly[i] - 1;
         end
      end
      load <= connEstablished && !reset;
   end
endmodule // server_link_model
